// [design/timer_pkg.sv]
// What this block does
// - 16-bit up count, read and written as low and high bytes
// - run bit off stops counting; gate enable qualifies counting by the gate
// - source field and oscillator bit choose the count clock; 11 reserved
// - system clock source advances once per system clock
// - external source counts rising edges, synchronised or not
// - counter mode needs a falling edge before the first rising edge
// - prescaler divides by 1, 2, 4 or 8; cleared on count writes
// - crystal oscillator runs when enabled, also during sleep
// - unsynchronised external counting continues in sleep; overflow wakes
// - switching sync modes may lose or add one increment
// - each byte read returns a valid byte of the live count
// - gated counting increments while the gate is active, else holds
// - gate is active when its level equals the polarity bit
// - gate source field: 00 gate pin, 01 eight-bit timer overflow
// - eight-bit timer wrap gives a low-to-high gate pulse
// - toggle mode routes the gate through a toggling flip-flop
// - overflow flag sets on FFFF to 0000; software clears it
package timer_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_GATE   = 8'h04;
  localparam logic [7:0] ADDR_LOW    = 8'h08;
  localparam logic [7:0] ADDR_HIGH   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // timer_control_reg fields
  localparam int CS_LSB      = 6;
  localparam int PS_LSB      = 4;
  localparam int OSCEN_BIT   = 3;
  localparam int SYNCDIS_BIT = 2;
  localparam int RUN_BIT     = 0;
  localparam logic [7:0] CTRL_MASK = 8'hFD;
  // gate_control_reg fields
  localparam int GE_BIT   = 7;
  localparam int GPOL_BIT = 6;
  localparam int GTM_BIT  = 5;
  localparam int GSS_LSB  = 0;
  localparam logic [7:0] GATE_MASK = 8'hE3;
  // status fields
  localparam int OVF_BIT = 0;
  // reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [7:0]  GATE_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // clock source codes
  localparam logic [1:0] SRC_INSTR = 2'h0;
  localparam logic [1:0] SRC_SYS   = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;
  // gate source codes
  localparam logic [1:0] GSRC_PIN  = 2'h0;
  localparam logic [1:0] GSRC_WRAP = 2'h1;
  // system clocks per instruction cycle, minus one
  localparam logic [1:0] INSTR_LAST = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : timer_pkg

// [design/pin_edge_sync.sv]
`timescale 1ns/1ns
module pin_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // pin
  input  wire logic din,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic stage1;
  logic stage2;
  logic last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      last   <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      last   <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~last;
  assign fall  = ~stage2 & last;
endmodule : pin_edge_sync

// [design/tick_prescaler.sv]
`timescale 1ns/1ns
module tick_prescaler #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       clear,
  input  wire logic [1:0] ratio,
  // ticks
  input  wire logic       tick_in,
  output logic            tick_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] last;

  // ratio n divides by 2**n
  assign last     = WIDTH'((1 << ratio) - 1);
  assign tick_out = tick_in & (count == last);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (tick_in) begin
      count <= (count == last) ? '0 : count + 1'b1;
    end
  end
endmodule : tick_prescaler

// [design/gated_sixteen_bit_timer.sv]
`timescale 1ns/1ns
module gated_sixteen_bit_timer #(
  parameter int ADDR_WIDTH = 8,
  parameter int PRE_WIDTH  = 3
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // pins
  input  wire logic                  ext_clock_pin,
  input  wire logic                  crystal_in_pin,
  output logic                       crystal_out_pin,
  input  wire logic                  gate_pin,
  // system
  input  wire logic                  sleep,
  input  wire logic                  eight_bit_timer_wrap,
  // status
  output logic                       overflow_flag,
  output logic                       overflow_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  timer_control_reg;
  logic [7:0]  gate_control_reg;
  logic [15:0] count;

  logic [1:0] clock_source_field;
  logic [1:0] prescale_field;
  logic       crystal_osc_enable;
  logic       sync_disable_bit;
  logic       run_bit;
  logic       gate_enable_bit;
  logic       gate_polarity_bit;
  logic       gate_toggle_bit;
  logic [1:0] gate_source_field;

  assign clock_source_field = timer_control_reg[timer_pkg::CS_LSB +: 2];
  assign prescale_field     = timer_control_reg[timer_pkg::PS_LSB +: 2];
  assign crystal_osc_enable = timer_control_reg[timer_pkg::OSCEN_BIT];
  assign sync_disable_bit   = timer_control_reg[timer_pkg::SYNCDIS_BIT];
  assign run_bit            = timer_control_reg[timer_pkg::RUN_BIT];
  assign gate_enable_bit    = gate_control_reg[timer_pkg::GE_BIT];
  assign gate_polarity_bit  = gate_control_reg[timer_pkg::GPOL_BIT];
  assign gate_toggle_bit    = gate_control_reg[timer_pkg::GTM_BIT];
  assign gate_source_field  = gate_control_reg[timer_pkg::GSS_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic       setup;
  logic       access;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wbyte;
  logic       wr_ctrl;
  logic       wr_gate;
  logic       wr_low;
  logic       wr_high;
  logic       wr_status;
  logic       count_write;

  // offsets that answer without a slave error
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == timer_pkg::ADDR_CTRL)  || (a == timer_pkg::ADDR_GATE) ||
             (a == timer_pkg::ADDR_LOW)   || (a == timer_pkg::ADDR_HIGH) ||
             (a == timer_pkg::ADDR_STATUS);
  endfunction : mapped

  // write strobe only in the answered access cycle
  assign setup       = psel & ~penable;
  assign access      = psel & penable & pready;
  assign wr          = access & pwrite;
  assign addr        = 8'(paddr);
  assign wbyte       = pwdata[7:0];
  assign wr_ctrl     = wr & (addr == timer_pkg::ADDR_CTRL);
  assign wr_gate     = wr & (addr == timer_pkg::ADDR_GATE);
  assign wr_low      = wr & (addr == timer_pkg::ADDR_LOW);
  assign wr_high     = wr & (addr == timer_pkg::ADDR_HIGH);
  assign wr_status   = wr & (addr == timer_pkg::ADDR_STATUS);
  assign count_write = wr_low | wr_high;

  // no wait state: answer in the first access cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped(addr);
    end
  end

  // byte reads of the live count are taken whole in one edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (addr)
        timer_pkg::ADDR_CTRL:   prdata <= {24'h000000, timer_control_reg};
        timer_pkg::ADDR_GATE:   prdata <= {24'h000000, gate_control_reg};
        timer_pkg::ADDR_LOW:    prdata <= {24'h000000, count[7:0]};
        timer_pkg::ADDR_HIGH:   prdata <= {24'h000000, count[15:8]};
        timer_pkg::ADDR_STATUS: prdata <= {31'h00000000, overflow_flag};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // reserved control bits read back zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg <= timer_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      timer_control_reg <= wbyte & timer_pkg::CTRL_MASK;
    end
  end

  // unused gate bits read back zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_control_reg <= timer_pkg::GATE_RESET;
    end else if (wr_gate) begin
      gate_control_reg <= wbyte & timer_pkg::GATE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ext_rise;
  logic ext_fall;
  logic xtal_level;
  logic xtal_rise;
  logic xtal_fall;
  logic gate_level;

  pin_edge_sync ext_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (ext_clock_pin),
    .level (),
    .rise  (ext_rise),
    .fall  (ext_fall)
  );

  pin_edge_sync xtal_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (crystal_in_pin),
    .level (xtal_level),
    .rise  (xtal_rise),
    .fall  (xtal_fall)
  );

  pin_edge_sync gate_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (gate_pin),
    .level (gate_level),
    .rise  (),
    .fall  ()
  );

  // inverting drive for the crystal, independent of sleep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crystal_out_pin <= 1'b0;
    end else begin
      crystal_out_pin <= crystal_osc_enable & ~xtal_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count clock selection
  logic [1:0] instr_phase;
  logic       instr_tick;
  logic       ext_sel;
  logic       src_rise;
  logic       src_fall;
  logic       armed;
  logic       src_tick;
  logic       osc_last;
  logic       rearm;

  // free-running instruction phase from reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  assign instr_tick = (instr_phase == timer_pkg::INSTR_LAST);
  assign ext_sel    = (clock_source_field == timer_pkg::SRC_EXT);
  assign src_rise   = crystal_osc_enable ? xtal_rise : ext_rise;
  assign src_fall   = crystal_osc_enable ? xtal_fall : ext_fall;
  assign rearm      = count_write | ~run_bit | ~ext_sel | (crystal_osc_enable ^ osc_last);

  // a swap between pin and crystal must not count a stale edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_last <= 1'b0;
    end else begin
      osc_last <= crystal_osc_enable;
    end
  end

  // first rising edge counts only after a falling edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (rearm) begin
      armed <= 1'b0;
    end else if (src_fall) begin
      armed <= 1'b1;
    end
  end

  // sleep halts internal sources and the synchronised path
  always_comb begin
    unique case (clock_source_field)
      timer_pkg::SRC_INSTR: src_tick = instr_tick & ~sleep;
      timer_pkg::SRC_SYS:   src_tick = ~sleep;
      timer_pkg::SRC_EXT:   src_tick = src_rise & armed &
                                       (sync_disable_bit | ~sleep);
      default:              src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // gate conditioning
  logic gate_raw;
  logic gate_cond;
  logic gate_cond_last;
  logic gate_toggle;
  logic gate_active;
  logic count_enable;

  always_comb begin
    unique case (gate_source_field)
      timer_pkg::GSRC_PIN:  gate_raw = gate_level;
      timer_pkg::GSRC_WRAP: gate_raw = eight_bit_timer_wrap;
      default:              gate_raw = 1'b0;
    endcase
  end

  // active when the gate level matches polarity
  assign gate_cond = ~(gate_raw ^ gate_polarity_bit);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cond_last <= 1'b0;
    end else begin
      gate_cond_last <= gate_cond;
    end
  end

  // toggle flop flips on each rising active gate edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_toggle <= 1'b0;
    end else if (!gate_toggle_bit) begin
      gate_toggle <= 1'b0;
    end else if (gate_cond && !gate_cond_last) begin
      gate_toggle <= ~gate_toggle;
    end
  end

  // counting needs the run bit and, with gate enable set, an active gate
  assign gate_active  = gate_toggle_bit ? gate_toggle : gate_cond;
  assign count_enable = run_bit & (~gate_enable_bit | gate_active);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  logic pre_tick;
  logic inc;
  logic wrap;

  // gate qualifies ticks ahead of the divider, freezing it too
  tick_prescaler #(
    .WIDTH (PRE_WIDTH)
  ) prescaler (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .clear    (count_write),
    .ratio    (prescale_field),
    .tick_in  (src_tick & count_enable),
    .tick_out (pre_tick)
  );

  // a sync-mode switch can drop or add one edge in the detector
  assign inc  = pre_tick;
  assign wrap = inc & (count == timer_pkg::COUNT_MAX);

  // a byte write wins over a coinciding increment
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= timer_pkg::COUNT_RESET;
    end else if (wr_low) begin
      count[7:0] <= wbyte;
    end else if (wr_high) begin
      count[15:8] <= wbyte;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow status
  logic clear_ovf;

  // software clears by writing one to the flag bit
  assign clear_ovf = wr_status & wbyte[timer_pkg::OVF_BIT];

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (clear_ovf) begin
      overflow_flag <= 1'b0;
    end
  end

  // wake only while asleep; only async external counting runs then
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_wake <= 1'b0;
    end else begin
      overflow_wake <= wrap & sleep;
    end
  end

endmodule : gated_sixteen_bit_timer

// [test/gated_sixteen_bit_timer_properties.sv]
`timescale 1ns/1ns
module timer_checker #(
  parameter int ADDR_WIDTH = 8
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // pins and status
  input wire logic                  crystal_in_pin,
  input wire logic                  crystal_out_pin,
  input wire logic                  sleep,
  input wire logic                  overflow_flag,
  input wire logic                  overflow_wake
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic mapped;
  logic clr;
  assign mapped = paddr inside {timer_pkg::ADDR_CTRL, timer_pkg::ADDR_GATE,
                  timer_pkg::ADDR_LOW, timer_pkg::ADDR_HIGH, timer_pkg::ADDR_STATUS};
  assign clr = psel & penable & pready & pwrite & pwdata[0] &
               (paddr == timer_pkg::ADDR_STATUS);
  //////////////////////////////////////////////////////////////////////////////
  AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_PREADY_SINGLE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_SLVERR_MAP: assert property (pready |-> pslverr == !mapped)
    else $error("slave error does not match address map");
  AST_READ_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_STATUS_READ: assert property (pready && !pwrite && paddr == timer_pkg::ADDR_STATUS
    |-> prdata[0] == $past(overflow_flag))
    else $error("status read differs from flag");
  AST_FLAG_STICKY: assert property (overflow_flag && !clr |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  AST_FLAG_CLEAR: assert property (clr |=> !overflow_flag)
    else $error("overflow flag not cleared");
  AST_WAKE_PULSE: assert property (overflow_wake |=> !overflow_wake)
    else $error("wake longer than one cycle");
  AST_WAKE_IN_SLEEP: assert property (overflow_wake |-> $past(sleep) || $past(sleep, 2))
    else $error("wake outside sleep");
  AST_CRYSTAL_DRIVE: assert property (crystal_out_pin &&
    $past(crystal_in_pin, 2) == $past(crystal_in_pin, 4) |-> !$past(crystal_in_pin, 3))
    else $error("crystal drive not inverted");
  cover property (pready && pslverr);
  cover property ($rose(overflow_flag));
  cover property (overflow_wake);
endmodule : timer_checker
bind gated_sixteen_bit_timer timer_checker #(.ADDR_WIDTH(ADDR_WIDTH)) timer_checker_inst (
  .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .crystal_in_pin, .crystal_out_pin, .sleep, .overflow_flag, .overflow_wake
);

// [test/pin_partner.sv]
`timescale 1ns/1ns
module pin_partner #(
  parameter int HALF = 4
) (
  // clock
  input wire logic clk,
  // bench controls
  input wire logic ext_go,
  input wire logic ext_idle,
  input wire logic gate_lvl,
  // device pins
  input wire logic crystal_out_pin,
  output logic     ext_clock_pin,
  output logic     crystal_in_pin,
  output logic     gate_pin
);
  int ext_t = 0;
  int xt_t  = 0;
  int quiet = 100;
  initial ext_clock_pin = 1'h0;
  initial crystal_in_pin = 1'h0;
  assign gate_pin = gate_lvl;
  // free clock while enabled, parked level otherwise
  always @(posedge clk) begin
    ext_t <= (ext_t == HALF - 1) ? 0 : ext_t + 1;
    if (!ext_go)
      ext_clock_pin <= ext_idle;
    else if (ext_t == HALF - 1)
      ext_clock_pin <= !ext_clock_pin;
  end
  // crystal swings while driven, rests low once the drive stops
  always @(posedge clk) begin
    quiet <= crystal_out_pin ? 0 : quiet + 1;
    xt_t <= (xt_t == HALF - 1) ? 0 : xt_t + 1;
    if (quiet >= 2 * HALF)
      crystal_in_pin <= 1'h0;
    else if (xt_t == HALF - 1)
      crystal_in_pin <= !crystal_in_pin;
  end
endmodule : pin_partner

// [test/gated_sixteen_bit_timer_tb_top.sv]
`timescale 1ns/1ns
module gated_sixteen_bit_timer_tb_top;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_clock_pin;
  logic        crystal_in_pin;
  logic        crystal_out_pin;
  logic        gate_pin;
  logic        sleep = 1'h0;
  logic        wrap = 1'h0;
  logic        ext_go = 1'h1;
  logic        ext_idle = 1'h0;
  logic        gate_lvl = 1'h0;
  logic        overflow_flag;
  logic        overflow_wake;
  logic [31:0] rd;
  logic        err;
  logic [15:0] cnt;
  int          mismatches = 0;
  int          check_count = 0;
  int          wakes = 0;
  logic [7:0]  regs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [7:0]  srcs [4] = '{8'h00, 8'h80, 8'h88, 8'hC0};
  int          sexp [4] = '{16, 8, 8, 0};
  int          stol [4] = '{2, 2, 2, 0};
  logic [7:0]  gts [8] = '{8'h80, 8'h80, 8'hC0, 8'hC0, 8'hC1, 8'hE1, 8'h82, 8'hC3};
  int          gexp [8] = '{67, 0, 0, 67, 2, 30, 67, 0};
  int          gtol [8] = '{2, 0, 0, 2, 1, 3, 2, 0};
  logic [7:0]  glvl = 8'h0A;
  logic [7:0]  gpul = 8'h30;
  always #2 ref_clk = !ref_clk;
  always @(posedge ref_clk) if (overflow_wake === 1'h1) wakes <= wakes + 1;
  gated_sixteen_bit_timer gated_sixteen_bit_timer_inst (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_clock_pin, .crystal_in_pin, .crystal_out_pin, .gate_pin, .sleep,
    .eight_bit_timer_wrap(wrap), .overflow_flag, .overflow_wake
  );
  pin_partner pin_partner_inst (
    .clk(ref_clk), .ext_go, .ext_idle, .gate_lvl, .crystal_out_pin, .ext_clock_pin,
    .crystal_in_pin, .gate_pin
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] near(input logic [15:0] c, input int e, input int t);
    int d;
    d = int'(c) - e;
    return $isunknown(c) ? 32'h0 : {31'h0, d <= t && d >= -t};
  endfunction : near
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      mismatches++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // program stopped, preset count, run a fixed window, stop, read count
  task automatic measure(input logic [7:0] ctl, input logic [7:0] gt, input logic [15:0] pre,
                         input logic pul, input logic run);
    apb(1'h1, 8'h00, {24'h0, ctl});
    apb(1'h1, 8'h04, {24'h0, gt});
    apb(1'h1, 8'h08, {24'h0, pre[7:0]});
    apb(1'h1, 8'h0C, {24'h0, pre[15:8]});
    repeat (16) @(posedge ref_clk);
    apb(1'h1, 8'h00, {24'h0, ctl[7:1], run});
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      wrap <= pul && (i == 10 || i == 40);
    end
    apb(1'h1, 8'h00, {24'h0, ctl});
    apb(1'h0, 8'h08, 32'h0);
    cnt[7:0] = rd[7:0];
    apb(1'h0, 8'h0C, 32'h0);
    cnt[15:8] = rd[7:0];
  endtask : measure
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    foreach (regs[i]) begin
      apb(1'h0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'h0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'h1, 8'h00, 32'hFE);
    apb(1'h0, 8'h00, 32'h0);
    check(rd, {24'h0, 8'hFE & timer_pkg::CTRL_MASK});
    apb(1'h1, 8'h04, 32'hFF);
    apb(1'h0, 8'h04, 32'h0);
    check(rd, {24'h0, timer_pkg::GATE_MASK});
    apb(1'h1, 8'h08, 32'hA5);
    apb(1'h1, 8'h0C, 32'h5A);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'hA5);
    apb(1'h0, 8'h0C, 32'h0);
    check(rd, 32'h5A);
    for (int k = 0; k < 4; k++) begin
      measure({2'h1, 2'(k), 4'h0}, 8'h00, 16'h0, 1'h0, 1'h1);
      check(near(cnt, 67 >> k, 2), 32'h1);
    end
    foreach (srcs[i]) begin
      measure(srcs[i], 8'h00, 16'h0, 1'h0, 1'h1);
      check(near(cnt, sexp[i], stol[i]), 32'h1);
    end
    measure(8'h40, 8'h80, 16'h0, 1'h0, 1'h0);
    check(near(cnt, 0, 0), 32'h1);
    foreach (gts[i]) begin
      gate_lvl <= glvl[i];
      measure(8'h40, gts[i], 16'h0, gpul[i], 1'h1);
      check(near(cnt, gexp[i], gtol[i]), 32'h1);
    end
    sleep <= 1'h1;
    measure(8'h40, 8'h00, 16'h0, 1'h0, 1'h1);
    check(near(cnt, 0, 0), 32'h1);
    measure(8'h80, 8'h00, 16'h0, 1'h0, 1'h1);
    check(near(cnt, 0, 0), 32'h1);
    measure(8'h84, 8'h00, 16'hFFFC, 1'h0, 1'h1);
    check(near(cnt, 4, 2), 32'h1);
    check({31'h0, overflow_flag}, 32'h1);
    check({31'h0, wakes != 0}, 32'h1);
    sleep <= 1'h0;
    apb(1'h1, 8'h10, 32'h1);
    apb(1'h0, 8'h10, 32'h0);
    check(rd, 32'h0);
    ext_go <= 1'h0;
    ext_idle <= 1'h1;
    apb(1'h1, 8'h00, 32'h80);
    apb(1'h1, 8'h08, 32'h0);
    apb(1'h1, 8'h0C, 32'h0);
    ext_idle <= 1'h0;
    repeat (8) @(posedge ref_clk);
    apb(1'h1, 8'h00, 32'h81);
    repeat (8) @(posedge ref_clk);
    ext_idle <= 1'h1;
    repeat (8) @(posedge ref_clk);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h0);
    ext_idle <= 1'h0;
    repeat (8) @(posedge ref_clk);
    ext_idle <= 1'h1;
    repeat (8) @(posedge ref_clk);
    apb(1'h0, 8'h08, 32'h0);
    check(rd, 32'h1);
    check({31'h0, crystal_out_pin}, 32'h0);
    summarize();
  end
endmodule : gated_sixteen_bit_timer_tb_top
